// *** logic/lcdcd_top.sv ***
// Contract
// - 01010bbb selects follower bias 1/5..1/12.
// - 1100rxxx sets row scan reverse.
// - 1010000c sets column scan reverse.
// - 0xAB starts the oscillator.
// - 1010100p enters or leaves sleep.
// - 0xE1 releases power save.
// - 0xE2 soft-resets registers, not power.
// - 0xE8 plus count v gives v+1 data bytes.
// - Byte after counted data is an instruction.
// - In 3-line mode select pin ignored.
// - 3-line interface is write only.
// - 0xFD enters extension mode 1.
// - 0xD1 enters extension mode 2.
// - 0x7B enters extension mode 3.
// - Set-1 commands decoded only in mode 1.
// - Mode 1 0x51 increments trim.
// - Mode 1 0x52 decrements trim.
// - Trim wraps, read as two's complement.
// - Contrast code is sum truncated to six bits.
// - Mode 1 0x00 returns to normal.
//
// Purpose: Decodes host instruction bytes into display control settings.
// Assumes: BYTE_VALID_I is a one-cycle strobe per received byte.
// Notes:   The interface carries no read path in 3-line mode.
`timescale 1ns/100ps
module lcdcd_top (
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  SYS_RST_I,
	// Incoming byte stream
	input  wire logic                  BYTE_VALID_I,
	input  wire logic [7:0]            BYTE_I,
	input  wire logic                  CMD_DATA_SELECT_I,
	input  wire logic                  SPI3_MODE_I,
	// Contrast register from the general set
	input  wire logic [5:0]            CONTRAST_REG_I,
	// Settings and status
	output lcdcd_pkg::lcdcd_cfg_t      CFG_O,
	output lcdcd_pkg::lcdcd_mode_t     MODE_O,
	output logic [5:0]                 CONTRAST_CODE_O,
	output logic                       DATA_VALID_O,
	output logic [7:0]                 DATA_O,
	output logic                       SOFT_RST_O,
	output logic                       EXT2_CMD_VALID_O,
	output logic                       EXT3_CMD_VALID_O,
	output logic [7:0]                 EXT_CMD_O
);
	import lcdcd_pkg::*;

	lcdcd_cfg_t  cfg_q;
	lcdcd_mode_t mode_q;
	logic [8:0]  len_q;
	logic        len_arm_q;
	logic [5:0]  code_q;
	logic        is_data;
	logic        is_cmd;
	logic        normal_cmd;
	logic        ext1_cmd;

	// ----------------------------------------------------------------
	// Command or data classification
	// ----------------------------------------------------------------
	// In 3-line mode the select pin is dropped and a running count marks data.
	always_comb begin
		if (SPI3_MODE_I) begin
			is_data = len_q != LEN_ZERO;
		end else begin
			is_data = CMD_DATA_SELECT_I;
		end
	end

	assign is_cmd     = BYTE_VALID_I && !is_data && !len_arm_q;
	assign normal_cmd = is_cmd && (mode_q == LCDCD_NORMAL);
	assign ext1_cmd   = is_cmd && (mode_q == LCDCD_EXT1);

	// ----------------------------------------------------------------
	// Data length counter for 3-line mode
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			len_arm_q <= 1'b0;
		end else if (BYTE_VALID_I && len_arm_q) begin
			// The count byte clears the arm flag and loads the length counter; it is neither command nor data.
			len_arm_q <= 1'b0;
		end else if (normal_cmd && SPI3_MODE_I && BYTE_I == OP_LEN_SET) begin
			len_arm_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			len_q <= LEN_ZERO;
		end else if (BYTE_VALID_I && len_arm_q) begin
			// Loading v plus one lets a zero count still carry one data byte.
			len_q <= {1'b0, BYTE_I} + LEN_ONE;
		end else if (BYTE_VALID_I && SPI3_MODE_I && len_q != LEN_ZERO) begin
			len_q <= len_q - LEN_ONE;
		end
	end

	// ----------------------------------------------------------------
	// Display data output
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			DATA_VALID_O <= 1'b0;
			DATA_O       <= 8'h00;
		end else begin
			DATA_VALID_O <= BYTE_VALID_I && is_data && !len_arm_q;
			if (BYTE_VALID_I && is_data && !len_arm_q) begin
				DATA_O <= BYTE_I;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command-set mode
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			mode_q <= LCDCD_NORMAL;
		end else if (normal_cmd) begin
			unique case (BYTE_I)
				OP_EXT1:     mode_q <= LCDCD_EXT1;
				OP_EXT2:     mode_q <= LCDCD_EXT2;
				OP_EXT3:     mode_q <= LCDCD_EXT3;
				OP_SOFT_RST: mode_q <= LCDCD_NORMAL;
				default:     mode_q <= mode_q;
			endcase
		end else if (is_cmd && BYTE_I == OP_RET_NORM) begin
			// Return to normal is honoured from every extension mode.
			mode_q <= LCDCD_NORMAL;
		end
	end

	// ----------------------------------------------------------------
	// General and extension set-1 settings
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			cfg_q <= CFG_RST;
		end else if (normal_cmd) begin
			if (BYTE_I == OP_SOFT_RST) begin
				cfg_q <= CFG_RST;
			end else if (BYTE_I[7:3] == OP_BIAS_HI5) begin
				cfg_q.bias_sel <= BYTE_I[2:0];
			end else if (BYTE_I[7:4] == OP_ROW_HI4) begin
				cfg_q.row_reverse <= BYTE_I[ROW_BIT];
			end else if (BYTE_I[7:1] == OP_COL_HI7) begin
				cfg_q.col_reverse <= BYTE_I[FLAG_BIT];
			end else if (BYTE_I == OP_OSC_ON) begin
				cfg_q.osc_on <= 1'b1;
			end else if (BYTE_I[7:1] == OP_SAVE_HI7) begin
				cfg_q.sleep <= BYTE_I[FLAG_BIT];
			end else if (BYTE_I == OP_WAKE) begin
				cfg_q.sleep <= 1'b0;
			end
		end else if (ext1_cmd) begin
			// Only the trim moves here; sets 2 and 3 leave all of these bits alone.
			if (BYTE_I == OP_TRIM_INC) begin
				cfg_q.trim <= cfg_q.trim + TRIM_ONE;
			end else if (BYTE_I == OP_TRIM_DEC) begin
				cfg_q.trim <= cfg_q.trim - TRIM_ONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Effective contrast code
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			code_q <= CODE_ZERO;
		end else begin
			// The trim is signed; the carry out of bit five is dropped.
			code_q <= CONTRAST_REG_I + {cfg_q.trim[4], cfg_q.trim};
		end
	end

	// ----------------------------------------------------------------
	// Strobes and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			SOFT_RST_O       <= 1'b0;
			EXT2_CMD_VALID_O <= 1'b0;
			EXT3_CMD_VALID_O <= 1'b0;
			EXT_CMD_O        <= 8'h00;
		end else begin
			// Set 2 and set 3 bytes are handed on to the logic that owns those sets.
			SOFT_RST_O       <= normal_cmd && BYTE_I == OP_SOFT_RST;
			EXT2_CMD_VALID_O <= is_cmd && mode_q == LCDCD_EXT2 && BYTE_I != OP_RET_NORM;
			EXT3_CMD_VALID_O <= is_cmd && mode_q == LCDCD_EXT3 && BYTE_I != OP_RET_NORM;
			if (is_cmd) begin
				EXT_CMD_O <= BYTE_I;
			end
		end
	end

	assign CFG_O           = cfg_q;
	assign MODE_O          = mode_q;
	assign CONTRAST_CODE_O = code_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_BIAS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I[7:3] == OP_BIAS_HI5 |=> cfg_q.bias_sel == $past(BYTE_I[2:0]))
		else $error("bias not loaded");
	AST_ROW: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I[7:4] == OP_ROW_HI4 |=> cfg_q.row_reverse == $past(BYTE_I[3]))
		else $error("row direction not loaded");
	AST_COL: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I[7:1] == OP_COL_HI7 |=> cfg_q.col_reverse == $past(BYTE_I[0]))
		else $error("column direction not loaded");
	AST_OSC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_OSC_ON |=> cfg_q.osc_on)
		else $error("oscillator not started");
	AST_SLEEP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I[7:1] == OP_SAVE_HI7 |=> cfg_q.sleep == $past(BYTE_I[0]))
		else $error("sleep flag wrong");
	AST_WAKE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_WAKE |=> !cfg_q.sleep)
		else $error("power save not released");
	AST_SRST: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_SOFT_RST |=> cfg_q == CFG_RST && SOFT_RST_O)
		else $error("soft reset incomplete");
	AST_LEN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		BYTE_VALID_I && len_arm_q |=> len_q == $past(BYTE_I) + 9'h001)
		else $error("length counter wrong");
	AST_CMD_AFTER: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SPI3_MODE_I && BYTE_VALID_I && len_q == 9'h001 |=> len_q == 9'h000)
		else $error("counter did not end data");
	AST_IGN_SEL: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SPI3_MODE_I && BYTE_VALID_I && len_q == 9'h000 && !len_arm_q |=> !DATA_VALID_O)
		else $error("select pin honoured in 3-line mode");
	AST_EXT1: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_EXT1 |=> mode_q == LCDCD_EXT1)
		else $error("mode 1 not entered");
	AST_EXT2: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_EXT2 |=> mode_q == LCDCD_EXT2)
		else $error("mode 2 not entered");
	AST_EXT3: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_EXT3 |=> mode_q == LCDCD_EXT3)
		else $error("mode 3 not entered");
	AST_TRIM_GATE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		mode_q != LCDCD_EXT1 |=> $stable(cfg_q.trim) || $past(normal_cmd && BYTE_I == OP_SOFT_RST))
		else $error("trim moved outside mode 1");
	AST_INC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		ext1_cmd && BYTE_I == OP_TRIM_INC |=> cfg_q.trim == $past(cfg_q.trim) + 5'h01)
		else $error("trim not incremented");
	AST_DEC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		ext1_cmd && BYTE_I == OP_TRIM_DEC |=> cfg_q.trim == $past(cfg_q.trim) - 5'h01)
		else $error("trim not decremented");
	AST_WRAP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		ext1_cmd && BYTE_I == OP_TRIM_INC && cfg_q.trim == 5'h0f |=> cfg_q.trim == 5'h10)
		else $error("trim did not wrap");
	AST_CODE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		1'b1 |=> code_q == 6'($past(CONTRAST_REG_I) + {$past(cfg_q.trim[4]), $past(cfg_q.trim)}))
		else $error("contrast code wrong");
	AST_RET: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		ext1_cmd && BYTE_I == OP_RET_NORM |=> mode_q == LCDCD_NORMAL)
		else $error("no return to normal");
	AST_RST_MODE: assert property (@(posedge CLK_I)
		SYS_RST_I |=> mode_q == LCDCD_NORMAL)
		else $error("mode not normal after reset");

	// ----------------------------------------------------------------
	// Checks on the 3-line data path
	// ----------------------------------------------------------------
	AST_ARM: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && SPI3_MODE_I && BYTE_I == OP_LEN_SET |=> len_arm_q)
		else $error("length set not armed");
	AST_ARM_4W: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && !SPI3_MODE_I && BYTE_I == OP_LEN_SET |=> !len_arm_q)
		else $error("length set armed outside 3-line mode");
	AST_COUNT_BYTE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		BYTE_VALID_I && len_arm_q |=> !len_arm_q && !DATA_VALID_O && $stable(mode_q))
		else $error("count byte treated as data or command");
	AST_DATA_RUN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SPI3_MODE_I && BYTE_VALID_I && len_q != LEN_ZERO |=> DATA_VALID_O && DATA_O == $past(BYTE_I))
		else $error("counted byte not passed as data");
	AST_DATA_DEC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SPI3_MODE_I && BYTE_VALID_I && len_q != LEN_ZERO |=> len_q == $past(len_q) - LEN_ONE)
		else $error("length counter did not step");
	AST_DATA_NOT_CMD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SPI3_MODE_I && BYTE_VALID_I && len_q != LEN_ZERO
		|=> $stable(mode_q) && $stable(cfg_q) && !SOFT_RST_O)
		else $error("counted byte decoded as command");

	// ----------------------------------------------------------------
	// Checks on the command sets
	// ----------------------------------------------------------------
	AST_SEL_4W: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		!SPI3_MODE_I && !len_arm_q && BYTE_VALID_I && CMD_DATA_SELECT_I
		|=> DATA_VALID_O && $stable(cfg_q))
		else $error("select pin not honoured in 4-line mode");
	AST_GEN_IGNORED: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		is_cmd && mode_q != LCDCD_NORMAL
		|=> $stable(cfg_q.bias_sel) && $stable(cfg_q.row_reverse) && $stable(cfg_q.col_reverse)
		&& $stable(cfg_q.osc_on) && $stable(cfg_q.sleep))
		else $error("general command taken in extension mode");
	AST_EXT2_PULSE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		is_cmd && mode_q == LCDCD_EXT2 && BYTE_I != OP_RET_NORM
		|=> EXT2_CMD_VALID_O && EXT_CMD_O == $past(BYTE_I))
		else $error("set 2 byte not passed on");
	AST_EXT3_PULSE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		is_cmd && mode_q == LCDCD_EXT3 && BYTE_I != OP_RET_NORM
		|=> EXT3_CMD_VALID_O && EXT_CMD_O == $past(BYTE_I))
		else $error("set 3 byte not passed on");
	AST_EXT_QUIET: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		is_cmd && mode_q == LCDCD_NORMAL |=> !EXT2_CMD_VALID_O && !EXT3_CMD_VALID_O)
		else $error("extension strobe in normal mode");
	AST_RET_ANY: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		is_cmd && BYTE_I == OP_RET_NORM |=> mode_q == LCDCD_NORMAL)
		else $error("return to normal missed");
	AST_NOP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_NOP |=> $stable(cfg_q) && $stable(mode_q) && !SOFT_RST_O)
		else $error("no-operation changed state");
	AST_RST_OUT: assert property (@(posedge CLK_I)
		SYS_RST_I
		|=> cfg_q == CFG_RST && code_q == CODE_ZERO && !DATA_VALID_O && !SOFT_RST_O)
		else $error("outputs not cleared by reset");
	AST_SRST_MODE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_SOFT_RST |=> mode_q == LCDCD_NORMAL && !len_arm_q)
		else $error("soft reset left a mode open");
	AST_TRIM_NORMAL: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		normal_cmd && BYTE_I == OP_TRIM_INC |=> $stable(cfg_q.trim) && cfg_q.bias_sel == $past(BYTE_I[2:0]))
		else $error("set 1 byte acted on in normal mode");
	AST_DEC_WRAP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		ext1_cmd && BYTE_I == OP_TRIM_DEC && cfg_q.trim == 5'h10 |=> cfg_q.trim == 5'h0f)
		else $error("trim did not wrap down");
	AST_OSC_SRC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$rose(cfg_q.osc_on) |-> $past(normal_cmd && BYTE_I == OP_OSC_ON))
		else $error("oscillator started without command");
	AST_SLEEP_SRC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$rose(cfg_q.sleep) |-> $past(normal_cmd && BYTE_I[7:1] == OP_SAVE_HI7))
		else $error("sleep entered without command");

	COV_EXT1_INC: cover property (@(posedge CLK_I) ext1_cmd && BYTE_I == OP_TRIM_INC);
	COV_LEN_RUN: cover property (@(posedge CLK_I) len_q == 9'h001 ##1 len_q == 9'h000);
	COV_WRAP: cover property (@(posedge CLK_I) cfg_q.trim == 5'h0f ##1 cfg_q.trim == 5'h10);
	COV_SLEEP: cover property (@(posedge CLK_I) cfg_q.sleep ##[1:20] !cfg_q.sleep);
	COV_EXT3_CMD: cover property (@(posedge CLK_I) EXT3_CMD_VALID_O);
endmodule

// *** logic/lcdcd_pkg.sv ***
// Purpose: Shared constants and types for the LCD command decoder.
// Assumes: One byte arrives per strobe, synchronous to the system clock.
// Notes:   Opcodes and CFG_RST live here; the bias field slice and the data and strobe reset values are coded in lcdcd_top.
package lcdcd_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [4:0] OP_BIAS_HI5  = 5'h0a;
	localparam logic [3:0] OP_ROW_HI4   = 4'hc;
	localparam logic [6:0] OP_COL_HI7   = 7'h50;
	localparam logic [6:0] OP_SAVE_HI7  = 7'h54;
	localparam logic [7:0] OP_OSC_ON    = 8'hab;
	localparam logic [7:0] OP_WAKE      = 8'he1;
	localparam logic [7:0] OP_SOFT_RST  = 8'he2;
	localparam logic [7:0] OP_NOP       = 8'he3;
	localparam logic [7:0] OP_LEN_SET   = 8'he8;
	localparam logic [7:0] OP_EXT1      = 8'hfd;
	localparam logic [7:0] OP_EXT2      = 8'hd1;
	localparam logic [7:0] OP_EXT3      = 8'h7b;
	localparam logic [7:0] OP_TRIM_INC  = 8'h51;
	localparam logic [7:0] OP_TRIM_DEC  = 8'h52;
	localparam logic [7:0] OP_RET_NORM  = 8'h00;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ROW_BIT   = 3;
	localparam int FLAG_BIT  = 0;
	// ----------------------------------------------------------------
	// Reset values and widths
	// ----------------------------------------------------------------
	localparam logic [2:0] BIAS_RST  = 3'h0;
	localparam logic [4:0] TRIM_RST  = 5'h00;
	localparam logic [4:0] TRIM_ONE  = 5'h01;
	localparam logic [8:0] LEN_ZERO  = 9'h000;
	localparam logic [8:0] LEN_ONE   = 9'h001;
	localparam logic [5:0] CODE_ZERO = 6'h00;

	typedef enum logic [1:0] {LCDCD_NORMAL, LCDCD_EXT1, LCDCD_EXT2, LCDCD_EXT3} lcdcd_mode_t;

	// Settings that the decoder presents to the display and power logic.
	typedef struct packed {
		logic [2:0] bias_sel;
		logic       row_reverse;
		logic       col_reverse;
		logic       osc_on;
		logic       sleep;
		logic [4:0] trim;
	} lcdcd_cfg_t;

	localparam lcdcd_cfg_t CFG_RST = '{BIAS_RST, 1'b0, 1'b0, 1'b0, 1'b0, TRIM_RST};
endpackage

// *** verif/lcdcd_host.sv ***
// Purpose: Host model that writes command and data bytes to the decoder.
// Assumes: One byte per call, held until the sampling edge takes it.
// Notes:   Released lines show the inverse of the last value driven.
`timescale 1ns/100ps
module lcdcd_host (
	// Clock
	input  wire logic       clk_i,
	// Byte stream to the decoder
	output logic            byte_valid_o,
	output logic [7:0]      byte_o,
	output logic            cmd_data_select_o
);
	initial begin
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
		cmd_data_select_o = 1'b0;
	end

	// Writes only; the host has no read strobe at all.
	task automatic send(input logic [7:0] b, input logic sel);
		@(posedge clk_i);
		byte_valid_o <= 1'b1;
		byte_o <= b;
		cmd_data_select_o <= sel;
		@(posedge clk_i);
		byte_valid_o <= 1'b0;
		byte_o <= ~b;
		cmd_data_select_o <= ~sel;
	endtask
endmodule

// *** verif/lcdcd_tb.sv ***
// Purpose: Self-checking bench for the LCD command decoder.
// Assumes: The host model drives bytes; the bench drives mode and contrast.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/100ps
module testbench;
	import lcdcd_pkg::*;
	logic        clk;
	logic        rst;
	logic        spi3;
	logic [5:0]  contrast;
	logic        bv;
	logic [7:0]  bt;
	logic        sel;
	lcdcd_cfg_t  cfg;
	lcdcd_mode_t mode;
	logic [5:0]  code;
	logic        dv;
	logic [7:0]  dout;
	logic [7:0]  dlast;
	logic [7:0]  ecmd;
	logic        srst;
	logic        e2v;
	logic        e3v;
	int          num_errors;
	int          checked;
	int          dcnt;
	int          scnt;
	int          xcnt;
	int          cycles;
	lcdcd_cfg_t  exp;

	lcdcd_host host (.clk_i(clk), .byte_valid_o(bv), .byte_o(bt), .cmd_data_select_o(sel));

	lcdcd_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .BYTE_VALID_I(bv), .BYTE_I(bt),
		.CMD_DATA_SELECT_I(sel), .SPI3_MODE_I(spi3), .CONTRAST_REG_I(contrast), .CFG_O(cfg),
		.MODE_O(mode), .CONTRAST_CODE_O(code), .DATA_VALID_O(dv), .DATA_O(dout), .SOFT_RST_O(srst),
		.EXT2_CMD_VALID_O(e2v), .EXT3_CMD_VALID_O(e3v), .EXT_CMD_O(ecmd));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Pulse counters and the cycle ceiling that cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (dv === 1'b1) begin
			dcnt++;
			dlast = dout;
		end
		if (srst === 1'b1) scnt++;
		if (e2v === 1'b1 || e3v === 1'b1) xcnt++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_general;
		exp = CFG_RST;
		chk("reset cfg", exp, cfg);
		chk("reset mode", LCDCD_NORMAL, mode);
		for (int i = 0; i < 8; i++) begin
			host.send({OP_BIAS_HI5, 3'(i)}, 1'b0);
			exp.bias_sel = 3'(i);
			settle();
			chk("bias", exp, cfg);
		end
		host.send({OP_ROW_HI4, 1'b1, 3'h7}, 1'b0);
		host.send({OP_COL_HI7, 1'b1}, 1'b0);
		host.send(OP_OSC_ON, 1'b0);
		host.send({OP_SAVE_HI7, 1'b1}, 1'b0);
		host.send(OP_NOP, 1'b0);
		host.send(8'hff, 1'b0);
		exp.row_reverse = 1'b1;
		exp.col_reverse = 1'b1;
		exp.osc_on = 1'b1;
		exp.sleep = 1'b1;
		settle();
		chk("general", exp, cfg);
		host.send(OP_WAKE, 1'b0);
		exp.sleep = 1'b0;
		settle();
		chk("wake", exp, cfg);
		host.send({OP_SAVE_HI7, 1'b1}, 1'b0);
		host.send({OP_SAVE_HI7, 1'b0}, 1'b0);
		settle();
		chk("sleep off", exp, cfg);
		$display("test general done");
	endtask

	task automatic t_ext1;
		host.send(OP_TRIM_INC, 1'b0);
		exp.bias_sel = 3'h1;
		host.send(OP_EXT1, 1'b0);
		settle();
		chk("mode1", LCDCD_EXT1, mode);
		chk("trim idle", exp, cfg);
		for (int i = 0; i < 16; i++) host.send(OP_TRIM_INC, 1'b0);
		host.send({OP_ROW_HI4, 1'b0, 3'h0}, 1'b0);
		exp.trim = 5'h10;
		settle();
		chk("trim wrap", exp, cfg);
		host.send(OP_TRIM_DEC, 1'b0);
		@(posedge clk);
		contrast <= 6'h3f;
		exp.trim = 5'h0f;
		settle();
		chk("trim dec", exp, cfg);
		chk("code", 12'h00e, code);
		host.send(OP_RET_NORM, 1'b0);
		host.send(OP_TRIM_INC, 1'b0);
		settle();
		chk("mode back", LCDCD_NORMAL, mode);
		chk("trim kept", exp, cfg);
		$display("test ext1 done");
	endtask

	task automatic t_ext23;
		xcnt = 0;
		host.send(OP_EXT2, 1'b0);
		settle();
		chk("mode2", LCDCD_EXT2, mode);
		host.send(OP_TRIM_INC, 1'b0);
		host.send(OP_RET_NORM, 1'b0);
		host.send(OP_EXT3, 1'b0);
		settle();
		chk("mode3", LCDCD_EXT3, mode);
		chk("trim ext2", exp, cfg);
		chk("ext cmds", 12'h001, 12'(xcnt));
		chk("ext last byte", {4'h0, OP_EXT3}, {4'h0, ecmd});
		host.send(8'h11, 1'b0);
		settle();
		chk("ext3 cmds", 12'h002, 12'(xcnt));
		chk("ext3 byte", 12'h011, {4'h0, ecmd});
		chk("trim ext3", exp, cfg);
		host.send(OP_RET_NORM, 1'b0);
		settle();
		chk("mode norm", LCDCD_NORMAL, mode);
		$display("test ext23 done");
	endtask

	task automatic t_spi3;
		@(posedge clk);
		spi3 <= 1'b1;
		dcnt = 0;
		scnt = 0;
		host.send(OP_LEN_SET, 1'b1);
		host.send(8'h01, 1'b1);
		host.send(OP_SOFT_RST, 1'b0);
		host.send(OP_EXT1, 1'b0);
		host.send({OP_SAVE_HI7, 1'b1}, 1'b1);
		exp.sleep = 1'b1;
		settle();
		chk("data count", 12'h002, 12'(dcnt));
		chk("last data", {4'h0, OP_EXT1}, {4'h0, dlast});
		chk("no soft rst", 12'h000, 12'(scnt));
		chk("cmd after", exp, cfg);
		chk("mode spi", LCDCD_NORMAL, mode);
		@(posedge clk);
		spi3 <= 1'b0;
		host.send(OP_SOFT_RST, 1'b0);
		settle();
		chk("soft pulse", 12'h001, 12'(scnt));
		chk("soft cfg", CFG_RST, cfg);
		chk("soft code", 12'h03f, code);
		host.send(OP_OSC_ON, 1'b1);
		settle();
		chk("four-wire data", 12'h003, 12'(dcnt));
		chk("four-wire byte", {4'h0, OP_OSC_ON}, {4'h0, dlast});
		chk("four-wire cfg", CFG_RST, cfg);
		$display("test spi3 and soft reset done");
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		spi3 = 1'b0;
		contrast = 6'h20;
		num_errors = 0;
		checked = 0;
		dcnt = 0;
		scnt = 0;
		xcnt = 0;
		cycles = 0;
		dlast = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_general();
		t_ext1();
		t_ext23();
		t_spi3();
		report_and_stop();
	end
endmodule
